// file: hw/csb_regs.svh
`ifndef CSB_REGS_SVH
`define CSB_REGS_SVH

// Register byte addresses on the control port
`define CSB_ADDR_RX_DATA_CONTROL 8'h04
`define CSB_ADDR_RX_STATUS       8'h16
`define CSB_ADDR_CS_A_FIRST      8'h23
`define CSB_ADDR_CS_B_FIRST      8'h28
`define CSB_ADDR_CS_LAST         8'h2c

// Receiver data control fields
`define CSB_CTL_INHIBIT_BIT      0
`define CSB_CTL_SRC_SEL_BIT      1
`define CSB_CTL_IRQ_EN_BIT       2
`define CSB_CTL_RESET            8'h00

// Receiver status fields
`define CSB_STS_GUARD_BIT        7
`define CSB_STS_RATE_HI          6
`define CSB_STS_RATE_LO          5
`define CSB_STS_LOCK_BIT         4
`define CSB_STS_GUARD_RESET      1'b0

// Error vector {crc, validity, confidence, biphase, parity}
`define CSB_ERR_GUARD_MASK       5'h17

// Block geometry
`define CSB_FRAMES_PER_BLOCK     192
`define CSB_BYTES_PER_CHAN       5
`define CSB_BITS_PER_CHAN        40

`endif

// file: hw/csb_pkg.sv
package csb_pkg;

	// Frame clock that paces the serial stream
	typedef enum logic
	{
		CSB_SRC_OUTPUT   = 1'b0,
		CSB_SRC_RECEIVER = 1'b1
	} csb_src_type;

	typedef logic [39:0] csb_chan_type;

endpackage

// file: hw/csb_top.sv
`timescale 1ns/1ps
`include "csb_regs.svh"
module csb_top
#(
	parameter int FRAMES = `CSB_FRAMES_PER_BLOCK
)
(
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic [7:0]           reg_addr,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic [7:0]           reg_wdata,
	output logic      [7:0]           reg_rdata,
	input  wire logic                 cbit_valid,
	input  wire logic                 block_start,
	input  wire logic                 cbit_a,
	input  wire logic                 cbit_b,
	input  wire logic                 err_biphase,
	input  wire logic                 err_conf,
	input  wire logic                 err_parity,
	input  wire logic                 err_crc,
	input  wire logic                 err_validity,
	input  wire logic                 pll_lock,
	input  wire logic [1:0]           decoded_receiver_rate,
	input  wire logic                 output_frame_clock,
	input  wire logic                 receiver_frame_clock,
	input  wire logic                 hw_mode,
	output logic                      cs_serial_pin,
	output logic                      general_output_pin,
	output logic                      xfer_irq
);
	import csb_pkg::*;
	localparam logic [7:0] LAST_IDX = 8'(FRAMES - 2);

	////////////////////////////////////////////////////////////////////////
	// State
	logic [7:0]   ctl, next_ctl, idx, next_idx, next_rdata;
	logic [4:0]   blk_err, next_blk_err, err_acc, next_err_acc;
	logic [1:0]   rate, next_rate, mode_s;
	logic [2:0]   ofc_s, rfc_s;
	csb_chan_type cap_a, cap_b, buf_a, buf_b;
	csb_chan_type next_cap_a, next_cap_b, next_buf_a, next_buf_b;
	logic         guard, next_guard, in_block, next_in_block;
	logic         nolock, next_nolock, ser, next_ser, next_irq;
	logic         hold_a, hold_b, next_hold_a, next_hold_b;
	logic         next_cs_pin, next_gpo_pin;

	logic [4:0]   cur_err, fin_err;
	logic         fin_lost, end_block, xfer_go;
	logic [7:0]   frame;
	logic         fc_now, fc_old;
	logic [7:0]   rd_idx;

	////////////////////////////////////////////////////////////////////////
	// Block tracking and capture
	assign cur_err = {err_crc, err_validity, err_conf, err_biphase,
		err_parity};
	assign frame = block_start ? 8'h00 : 8'(idx + 8'h01);
	assign end_block = cbit_valid && !block_start && in_block &&
		idx == LAST_IDX;
	assign fin_err = err_acc | cur_err;
	assign fin_lost = nolock | !pll_lock;
	// Guard decides whether errors other than validity matter; lock loss always blocks
	assign xfer_go = end_block && !ctl[`CSB_CTL_INHIBIT_BIT] &&
		!fin_lost &&
		!(guard && |(fin_err & `CSB_ERR_GUARD_MASK));

	always_comb
	begin
		next_idx = idx;
		next_in_block = in_block;
		next_err_acc = err_acc;
		next_nolock = nolock;
		next_cap_a = cap_a;
		next_cap_b = cap_b;
		next_hold_a = hold_a;
		next_hold_b = hold_b;
		next_buf_a = buf_a;
		next_buf_b = buf_b;
		next_rate = rate;
		next_blk_err = blk_err;
		if (cbit_valid)
		begin
			next_idx = frame;
			next_hold_a = cbit_a;
			next_hold_b = cbit_b;
			if (block_start)
			begin
				next_in_block = 1'b1;
				next_err_acc = cur_err;
				next_nolock = !pll_lock;
			end
			else
			begin
				next_err_acc = fin_err;
				next_nolock = fin_lost;
			end
			// MSB of byte 0 gets frame 0, so bit 39-frame
			if (frame < 8'(`CSB_BITS_PER_CHAN))
			begin
				next_cap_a[6'(39 - frame)] = cbit_a;
				next_cap_b[6'(39 - frame)] = cbit_b;
			end
		end
		if (end_block)
		begin
			next_in_block = 1'b0;
			next_blk_err = fin_err;
		end
		// Both channels copied in one edge so reads never mix blocks
		if (xfer_go)
		begin
			next_buf_a = cap_a;
			next_buf_b = cap_b;
			next_rate = decoded_receiver_rate;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control port
	assign rd_idx = 8'(reg_addr - `CSB_ADDR_CS_A_FIRST);

	always_comb
	begin
		next_ctl = ctl;
		next_guard = guard;
		next_rdata = reg_rdata;
		if (reg_wr && reg_addr == `CSB_ADDR_RX_DATA_CONTROL)
			next_ctl = reg_wdata;
		if (reg_wr && reg_addr == `CSB_ADDR_RX_STATUS)
			next_guard = reg_wdata[`CSB_STS_GUARD_BIT];
		if (reg_rd)
		begin
			// Unmapped addresses read as zero
			next_rdata = 8'h00;
			if (reg_addr == `CSB_ADDR_RX_DATA_CONTROL)
				next_rdata = ctl;
			else if (reg_addr == `CSB_ADDR_RX_STATUS)
				next_rdata = {guard, rate, !nolock, blk_err[3:0]};
			else if (reg_addr >= `CSB_ADDR_CS_A_FIRST &&
				reg_addr <= `CSB_ADDR_CS_LAST)
			begin
				if (rd_idx < 8'(`CSB_BYTES_PER_CHAN))
					next_rdata = buf_a[8*(4 - rd_idx) +: 8];
				else
					next_rdata = buf_b[8*(9 - rd_idx) +: 8];
			end
		end
		next_irq = xfer_go && ctl[`CSB_CTL_IRQ_EN_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Serial stream out, A on rising and B on falling edge
	assign fc_now = ctl[`CSB_CTL_SRC_SEL_BIT] == CSB_SRC_RECEIVER ?
		rfc_s[1] : ofc_s[1];
	assign fc_old = ctl[`CSB_CTL_SRC_SEL_BIT] == CSB_SRC_RECEIVER ?
		rfc_s[2] : ofc_s[2];

	always_comb
	begin
		next_ser = ser;
		if (fc_now && !fc_old)
			next_ser = hold_a;
		else if (!fc_now && fc_old)
			next_ser = hold_b;
		next_cs_pin = mode_s[1] ? next_ser : 1'b0;
		next_gpo_pin = mode_s[1] ? 1'b0 : next_ser;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers; the frame clock and hw_mode pins pass two flops before use
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctl <= `CSB_CTL_RESET;
			guard <= `CSB_STS_GUARD_RESET;
			{rate, blk_err, err_acc} <= 12'h000;
			{cap_a, cap_b} <= 80'h0;
			{buf_a, buf_b} <= 80'h0;
			idx <= 8'h00;
			in_block <= 1'b0;
			nolock <= 1'b1;
			{hold_a, hold_b, ser} <= 3'h0;
			{ofc_s, rfc_s, mode_s} <= 8'h00;
			reg_rdata <= 8'h00;
			{xfer_irq, cs_serial_pin, general_output_pin} <= 3'h0;
		end
		else
		begin
			ctl <= next_ctl;
			guard <= next_guard;
			rate <= next_rate;
			blk_err <= next_blk_err;
			cap_a <= next_cap_a;
			cap_b <= next_cap_b;
			buf_a <= next_buf_a;
			buf_b <= next_buf_b;
			idx <= next_idx;
			in_block <= next_in_block;
			err_acc <= next_err_acc;
			nolock <= next_nolock;
			hold_a <= next_hold_a;
			hold_b <= next_hold_b;
			ofc_s <= {ofc_s[1:0], output_frame_clock};
			rfc_s <= {rfc_s[1:0], receiver_frame_clock};
			mode_s <= {mode_s[0], hw_mode};
			ser <= next_ser;
			reg_rdata <= next_rdata;
			xfer_irq <= next_irq;
			cs_serial_pin <= next_cs_pin;
			general_output_pin <= next_gpo_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks; gap counter tracks frames since the last transfer
	logic [8:0] gap;
	logic       seen;
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			gap <= 9'h000;
			seen <= 1'b0;
		end
		else
		begin
			if (xfer_go)
				gap <= 9'h000;
			else if (cbit_valid && gap != 9'h1ff)
				gap <= 9'(gap + 9'h001);
			if (xfer_go)
				seen <= 1'b1;
		end
	end

	sequence seq_transfer;
		xfer_go ##1 1'b1;
	endsequence

	sequence seq_rise;
		fc_now && !fc_old;
	endsequence

	chk_hold_unless_xfer: assert property (@(posedge mclk) disable iff (!rstn)
		!xfer_go |=> $stable(buf_a) && $stable(buf_b))
		else $error("readable buffer changed without transfer");
	chk_both_channels: assert property (@(posedge mclk) disable iff (!rstn)
		seq_transfer |-> buf_a == $past(cap_a) && buf_b == $past(cap_b))
		else $error("transfer did not copy both channels");
	chk_lock_blocks: assert property (@(posedge mclk) disable iff (!rstn)
		end_block && fin_lost |-> !xfer_go)
		else $error("transfer despite lock loss");
	chk_guard_errors: assert property (@(posedge mclk) disable iff (!rstn)
		end_block && guard && (err_acc[4] || |err_acc[2:0] || err_crc ||
		err_conf || err_biphase || err_parity) |-> !xfer_go)
		else $error("transfer despite block error");
	chk_inhibit_stops: assert property (@(posedge mclk) disable iff (!rstn)
		ctl[`CSB_CTL_INHIBIT_BIT] |-> !xfer_go)
		else $error("transfer while inhibited");
	chk_irq_on_xfer: assert property (@(posedge mclk) disable iff (!rstn)
		xfer_go && ctl[`CSB_CTL_IRQ_EN_BIT] |=> xfer_irq ##1 !xfer_irq)
		else $error("interrupt missing or too long");
	chk_msb_first: assert property (@(posedge mclk) disable iff (!rstn)
		cbit_valid && block_start |=> cap_a[39] == $past(cbit_a))
		else $error("first bit not in byte 0 msb");
	chk_block_gap: assert property (@(posedge mclk) disable iff (!rstn)
		xfer_go && seen |-> gap >= 9'(FRAMES - 1))
		else $error("transfers closer than one block");
	chk_serial_rise: assert property (@(posedge mclk) disable iff (!rstn)
		seq_rise |=> ser == $past(hold_a))
		else $error("serial bit wrong on frame clock rise");
	chk_read_byte0: assert property (@(posedge mclk) disable iff (!rstn)
		reg_rd && reg_addr == `CSB_ADDR_CS_A_FIRST |=>
		reg_rdata == $past(buf_a[39:32]))
		else $error("byte 0 readback wrong");
endmodule

// file: dv/csb_dec_model.sv
`timescale 1ns/1ps
module csb_dec_model
(
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        go,
	input  wire logic [39:0] a_bits,
	input  wire logic [39:0] b_bits,
	input  wire logic [4:0]  err,
	input  wire logic        drop,
	input  wire logic [7:0]  nfr,
	output logic             cbit_valid,
	output logic             block_start,
	output logic             cbit_a,
	output logic             cbit_b,
	output logic [4:0]       errs,
	output logic             pll_lock,
	output logic             busy
);
	logic [7:0] fr;

	// One frame every other cycle; bits past byte 4 are a fixed tail
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			{busy, cbit_valid, block_start, cbit_a, cbit_b} <= 5'h00;
			{errs, fr} <= 13'h0000;
			pll_lock <= 1'b1;
		end
		else
		begin
			// Idle data lines toggle so stale bits never look valid
			cbit_valid <= 1'b0;
			block_start <= 1'b0;
			errs <= 5'h00;
			cbit_a <= ~cbit_a;
			cbit_b <= ~cbit_b;
			pll_lock <= 1'b1;
			if (go && !busy)
			begin
				busy <= 1'b1;
				fr <= 8'h00;
			end
			else if (busy && !cbit_valid)
			begin
				cbit_valid <= 1'b1;
				block_start <= (fr == 8'h00);
				cbit_a <= (fr < 8'h28) ? a_bits[6'(8'h27 - fr)] : 1'b1;
				cbit_b <= (fr < 8'h28) ? b_bits[6'(8'h27 - fr)] : 1'b0;
				errs <= (fr == 8'h05) ? err : 5'h00;
				pll_lock <= !(drop && fr == 8'h05);
				fr <= fr + 8'h01;
				busy <= (fr + 8'h01) < nfr;
			end
		end
	end
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import csb_pkg::*;
	typedef struct packed
	{
		logic [7:0] ctl;
		logic       guard;
		logic [4:0] err;
		logic       drop;
		logic [7:0] nfr;
		logic [1:0] rate;
		logic       xfer;
	} csb_row_type;
	// ctl, guard, error {crc,val,conf,bi,par}, lock drop, frames, rate, moved
	csb_row_type rows [11] = '{
		'{8'h04, 1'b0, 5'h00, 1'b0, 8'h30, 2'h1, 1'b1},
		'{8'h04, 1'b0, 5'h02, 1'b0, 8'h30, 2'h2, 1'b1},
		'{8'h04, 1'b1, 5'h01, 1'b0, 8'h30, 2'h3, 1'b0},
		'{8'h04, 1'b1, 5'h02, 1'b0, 8'h30, 2'h0, 1'b0},
		'{8'h04, 1'b1, 5'h04, 1'b0, 8'h30, 2'h1, 1'b0},
		'{8'h04, 1'b1, 5'h10, 1'b0, 8'h30, 2'h2, 1'b0},
		'{8'h04, 1'b1, 5'h08, 1'b0, 8'h30, 2'h3, 1'b1},
		'{8'h04, 1'b0, 5'h00, 1'b1, 8'h30, 2'h0, 1'b0},
		'{8'h05, 1'b0, 5'h00, 1'b0, 8'h30, 2'h1, 1'b0},
		'{8'h04, 1'b0, 5'h00, 1'b0, 8'h14, 2'h2, 1'b0},
		'{8'h00, 1'b0, 5'h00, 1'b0, 8'h30, 2'h3, 1'b1}};
	logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
	logic drop = 1'b0, hw = 1'b0, ofc = 1'b0, rfc = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, nfr = 8'h30, irqs;
	logic [1:0] rate = 2'h0;
	logic [4:0] err = 5'h00, errs;
	logic [39:0] a_bits = 40'h0, b_bits = 40'h0, cur_a = 40'h0;
	logic [39:0] cur_b = 40'h0;
	logic valid, bstart, ca, cb, lock, busy, cs_pin, gp_pin, irq;
	logic [7:0] reg_rdata;
	int num_errors = 0, n_checks = 0, cyc = 0;
	csb_row_type r;

	csb_top #(.FRAMES(48)) dut (.mclk(mclk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cbit_valid(valid),
		.block_start(bstart), .cbit_a(ca), .cbit_b(cb),
		.err_biphase(errs[1]), .err_conf(errs[2]), .err_parity(errs[0]),
		.err_crc(errs[4]), .err_validity(errs[3]), .pll_lock(lock),
		.decoded_receiver_rate(rate), .output_frame_clock(ofc),
		.receiver_frame_clock(rfc), .hw_mode(hw), .cs_serial_pin(cs_pin),
		.general_output_pin(gp_pin), .xfer_irq(irq));
	csb_dec_model dec (.mclk(mclk), .rstn(rstn), .go(go), .a_bits(a_bits),
		.b_bits(b_bits), .err(err), .drop(drop), .nfr(nfr),
		.cbit_valid(valid), .block_start(bstart), .cbit_a(ca), .cbit_b(cb),
		.errs(errs), .pll_lock(lock), .busy(busy));

	////////////////////////////////////////////////////////////////////////
	// 25 MHz clock and hang guard
	initial forever #20 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 9000)
		begin
			num_errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("FAIL t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// Strobes rise on one edge and drop on the next, never reused at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		chk(reg_rdata, e);
	endtask

	// Frame clock step, then long enough for sync and edge detect
	task automatic fclk(input logic src, input logic lvl);
		if (src)
			rfc <= lvl;
		else
			ofc <= lvl;
		repeat (6) @(posedge mclk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge mclk);
		rstn <= 1'b1;
		rc(8'h04, 8'h00);
		rc(8'h16, 8'h00);
		rc(8'h23, 8'h00);
		rc(8'h2c, 8'h00);
		for (int i = 0; i < 11; i++)
		begin
			r = rows[i];
			wr(8'h04, r.ctl);
			wr(8'h16, {r.guard, 7'h00});
			a_bits <= 40'hc5a396f01e + 40'(i) * 40'h0102030405;
			b_bits <= ~(40'hc5a396f01e + 40'(i) * 40'h0102030405);
			{err, drop, nfr, rate} <= {r.err, r.drop, r.nfr, r.rate};
			go <= 1'b1;
			@(posedge mclk);
			go <= 1'b0;
			irqs = 8'h00;
			// Partner paces two cycles per frame
			repeat (2 * 48 + 8) @(posedge mclk)
				irqs += {7'h00, irq === 1'b1};
			chk(irqs, {7'h00, r.xfer & r.ctl[2]});
			if (r.xfer)
				{cur_a, cur_b} = {a_bits, b_bits};
			for (int k = 0; k < 5; k++)
			begin
				rc(8'h23 + 8'(k), cur_a[39 - 8 * k -: 8]);
				rc(8'h28 + 8'(k), cur_b[39 - 8 * k -: 8]);
			end
			if (r.xfer)
				rc(8'h16, {r.guard, r.rate, 1'b1, r.err[3:0]});
		end
		// Read-only places ignore writes, holes read zero
		wr(8'h23, 8'hff);
		rc(8'h23, cur_a[39:32]);
		rc(8'h30, 8'h00);
		wr(8'h16, 8'hff);
		rc(8'h16, 8'hf0);
		// Tail frames end with A=1, B=0; both modes, both clocks
		for (int m = 0; m < 2; m++)
			for (int s = 0; s < 2; s++)
			begin
				wr(8'h04, {6'h00, 1'(s), 1'b0});
				hw <= 1'(m);
				fclk(1'(s), 1'b1);
				chk({6'h00, cs_pin, gp_pin}, {6'h00, 1'(m), 1'(!m)});
				fclk(1'(s), 1'b0);
				chk({6'h00, cs_pin, gp_pin}, 8'h00);
				fclk(1'(!s), 1'b1);
				chk({6'h00, cs_pin, gp_pin}, 8'h00);
				fclk(1'(!s), 1'b0);
			end
		complete_run();
	end
endmodule
